// File: hdl/sensor_ctrl_regs.vh
// Register map constants for the primary sensor control register.
// Assumes inclusion by bare name from the control bank and its timer.
`ifndef SENSOR_CTRL_REGS_VH
`define SENSOR_CTRL_REGS_VH

// Register address on the internal serial register port
`define CTRL_PRIMARY_ADDR 8'h15

// Field positions
`define CTRL_RST_BIT 7
`define CTRL_ST_AXIS_HI 6
`define CTRL_ST_AXIS_LO 5
`define CTRL_SELFTEST_POLARITY_BIT 4
`define CTRL_WIRE_BIT 3
`define CTRL_FSR_HI 2
`define CTRL_FSR_LO 1
`define CTRL_ACTIVE_BIT 0

// Self-test axis encodings
`define ST_AXIS_OFF 2'h0
`define ST_AXIS_X 2'h1
`define ST_AXIS_Z 2'h2

// Full-scale range encodings
`define FSR_2G 2'h0
`define FSR_4G 2'h1
`define FSR_8G 2'h2
`define FSR_16G 2'h3

// Reset values per boot strap level
`define CTRL_RESET_STRAP_LOW 8'h00
`define CTRL_RESET_STRAP_HIGH 8'h03

// Oscillator periods between closed request and reset sequence start
`define RST_DELAY_LF_TICKS 4'hA

// Cycles of settling after async reset before straps are trusted
`define STRAP_SETTLE_CYCLES 2'h3

`endif

// File: hdl/soft_reset_timer.v
// Delay timer between a soft reset request and the reset sequence.
// Assumes lf_tick is a one-cycle pulse per low-frequency oscillator period, same clock.
`timescale 1ns/1ns
`include "sensor_ctrl_regs.vh"

module soft_reset_timer #(
	parameter CNT_W = 4,
	parameter [CNT_W-1:0] TICKS = `RST_DELAY_LF_TICKS
)
(
	input wire mclk,
	input wire rst_n,
	input wire start,
	input wire lf_tick,
	output reg fire
);

	reg [CNT_W-1:0] cnt_q; // Ticks still to wait
	reg run_q; // Counting in progress

	// Count oscillator ticks once started, fire one pulse at the end
	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_q <= {CNT_W{1'b0}};
			run_q <= 1'b0;
			fire <= 1'b0;
		end
		else
		begin
			fire <= 1'b0;
			// Skip the fire cycle: start may still be high then and would retrigger
			if (start && !run_q && !fire)
			begin
				// Load the full oscillator count
				cnt_q <= TICKS;
				run_q <= 1'b1;
			end
			else if (run_q && lf_tick)
			begin
				if (cnt_q == {{(CNT_W-1){1'b0}}, 1'b1})
				begin
					// Last tick elapsed, sequence begins
					run_q <= 1'b0;
					fire <= 1'b1;
				end
				cnt_q <= cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
			end
		end
	end

endmodule

// File: hdl/sensor_control_register.v
// Primary sensor control register with soft reset sequencing.
// Assumes a serial front end on mclk giving write/read strobes and an end-of-transfer pulse.
`timescale 1ns/1ns
`include "sensor_ctrl_regs.vh"

// Function
// - Writing bit 7 one requests soft reset
// - Reset accepted in every operating state
// - Soft reset reloads defaults into every field
// - Reset waits for stop or chip-select release
// - Sequence starts ten oscillator ticks after the closed request
// - Axis field: 00 off, 01 X, 10 Z
// - Bit 4 picks self-test displacement direction
// - Bit 3 selects 3-wire SPI, SPI only
// - Three-wire: MOSI bidirectional, MISO high impedance
// - Power-on or hibernate exit selects 4-wire
// - Strap high resets range and active to one
// - Bits 2:1 select 2/4/8/16 g range
// - Bit 0 standby zero, active one
// - Trigger pin mode makes active bit read-only
module sensor_control_register (
	input wire mclk,
	input wire rst_n,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	output reg [7:0] reg_rdata,
	input wire xfer_done,
	input wire lf_tick,
	input wire hibernate_exit,
	input wire trigger_pin_mode_select,
	input wire boot_mode_strap,
	input wire host_interface_select,
	input wire trig_pin_level,
	output reg soft_reset_pulse,
	output reg selftest_x_en,
	output reg selftest_z_en,
	output reg selftest_polarity,
	output reg [1:0] full_scale_range,
	output reg active_mode,
	output reg spi_three_wire,
	output reg mosi_bidir,
	output reg miso_hiz
);

	// Synchronisers for pin inputs; first stage read only by second
	reg strap_s1_q, strap_s2_q;
	reg intf_s1_q, intf_s2_q;
	reg trig_s1_q, trig_s2_q;

	// Register fields
	reg rst_pend_q; // Soft reset requested, not yet sequenced
	reg [1:0] st_axis_q; // Self-test axis
	reg selftest_polarity_q; // Self-test polarity
	reg wire3_q; // Three-wire SPI request
	reg [1:0] fsr_q; // Full-scale range
	reg active_q; // Active mode bit

	reg armed_q; // Request seen and transfer closed
	reg [1:0] settle_q; // Post-reset strap settling count
	reg boot_load_q; // Strap defaults still to be loaded
	wire seq_fire; // Reset sequence begins this cycle
	wire addr_hit;
	wire [7:0] dflt; // Strap dependent defaults
	wire [7:0] reg_view; // Register as read back

	assign addr_hit = (reg_addr == `CTRL_PRIMARY_ADDR);
	// Strap level chooses the reset image
	assign dflt = strap_s2_q ? `CTRL_RESET_STRAP_HIGH : `CTRL_RESET_STRAP_LOW;

	// Pin synchronisers
	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			strap_s1_q <= 1'b0;
			strap_s2_q <= 1'b0;
			intf_s1_q <= 1'b0;
			intf_s2_q <= 1'b0;
			trig_s1_q <= 1'b0;
			trig_s2_q <= 1'b0;
		end
		else
		begin
			strap_s1_q <= boot_mode_strap;
			strap_s2_q <= strap_s1_q;
			intf_s1_q <= host_interface_select;
			intf_s2_q <= intf_s1_q;
			trig_s1_q <= trig_pin_level;
			trig_s2_q <= trig_s1_q;
		end
	end

	// Strap catch: wait for the synchroniser to fill before loading defaults
	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			settle_q <= 2'h0;
			boot_load_q <= 1'b1;
		end
		else if (boot_load_q)
		begin
			if (settle_q == `STRAP_SETTLE_CYCLES)
				boot_load_q <= 1'b0; // Defaults loaded this cycle
			else
				settle_q <= settle_q + 2'h1;
		end
	end

	// Arm once the request is pending and the bus transaction has ended.
	// Waiting here keeps the host's own frame from being cut short.
	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			armed_q <= 1'b0;
		else if (seq_fire)
			armed_q <= 1'b0;
		else if (rst_pend_q && xfer_done)
			armed_q <= 1'b1;
	end

	// Ten oscillator periods from closed request to sequence start
	soft_reset_timer #(
		.CNT_W(4),
		.TICKS(`RST_DELAY_LF_TICKS)
	) u_timer (
		.mclk(mclk),
		.rst_n(rst_n),
		.start(armed_q),
		.lf_tick(lf_tick),
		.fire(seq_fire)
	);

	// Register fields: load, reload on soft reset, host writes
	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			// Power-on image; strap level applied once settled
			rst_pend_q <= 1'b0;
			st_axis_q <= `ST_AXIS_OFF;
			selftest_polarity_q <= 1'b0;
			wire3_q <= 1'b0;
			fsr_q <= `FSR_2G;
			active_q <= 1'b0;
		end
		else if ((boot_load_q && settle_q == `STRAP_SETTLE_CYCLES) || seq_fire)
		begin
			// Reload all fields, request bit self-clears
			rst_pend_q <= dflt[`CTRL_RST_BIT];
			st_axis_q <= dflt[`CTRL_ST_AXIS_HI:`CTRL_ST_AXIS_LO];
			selftest_polarity_q <= dflt[`CTRL_SELFTEST_POLARITY_BIT];
			wire3_q <= dflt[`CTRL_WIRE_BIT];
			fsr_q <= dflt[`CTRL_FSR_HI:`CTRL_FSR_LO];
			active_q <= dflt[`CTRL_ACTIVE_BIT];
		end
		else if (hibernate_exit)
		begin
			// Leaving hibernate forces 4-wire SPI
			wire3_q <= 1'b0;
		end
		else if (reg_wr && addr_hit && !boot_load_q)
		begin
			// Request taken in any mode; once pending it stays pending
			if (reg_wdata[`CTRL_RST_BIT])
				rst_pend_q <= 1'b1;
			st_axis_q <= reg_wdata[`CTRL_ST_AXIS_HI:`CTRL_ST_AXIS_LO];
			selftest_polarity_q <= reg_wdata[`CTRL_SELFTEST_POLARITY_BIT];
			wire3_q <= reg_wdata[`CTRL_WIRE_BIT];
			fsr_q <= reg_wdata[`CTRL_FSR_HI:`CTRL_FSR_LO];
			// Active bit frozen while trigger pin controls mode
			if (!trigger_pin_mode_select)
				active_q <= reg_wdata[`CTRL_ACTIVE_BIT];
		end
	end

	// Read image: active bit reflects the effective operating mode
	assign reg_view = {rst_pend_q, st_axis_q, selftest_polarity_q, wire3_q, fsr_q,
		(trigger_pin_mode_select ? trig_s2_q : active_q)};

	// Read data register; unmatched address reads zero
	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			reg_rdata <= 8'h00;
		else if (reg_rd)
			reg_rdata <= addr_hit ? reg_view : 8'h00;
	end

	// Registered decode of fields onto the block's control outputs
	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			soft_reset_pulse <= 1'b0;
			selftest_x_en <= 1'b0;
			selftest_z_en <= 1'b0;
			selftest_polarity <= 1'b0;
			full_scale_range <= `FSR_2G;
			active_mode <= 1'b0;
			spi_three_wire <= 1'b0;
			mosi_bidir <= 1'b0;
			miso_hiz <= 1'b0;
		end
		else
		begin
			// Reset of all functional blocks, one cycle
			soft_reset_pulse <= seq_fire;
			// Code 11 is undefined and treated as off
			selftest_x_en <= (st_axis_q == `ST_AXIS_X);
			selftest_z_en <= (st_axis_q == `ST_AXIS_Z);
			selftest_polarity <= selftest_polarity_q;
			full_scale_range <= fsr_q;
			// Trigger pin drives mode directly when selected
			active_mode <= trigger_pin_mode_select ? trig_s2_q : active_q;
			// Wire count ignored unless SPI is strapped
			spi_three_wire <= intf_s2_q & wire3_q;
			mosi_bidir <= intf_s2_q & wire3_q;
			miso_hiz <= intf_s2_q & wire3_q;
		end
	end

endmodule

// File: tb/sensor_control_register_monitor.sv
// Port checker for the primary sensor control register.
// Assumes straps change only under reset and no plain write lands on a reload.
`timescale 1ns/1ns
module sensor_control_register_monitor (
	input mclk,
	input rst_n,
	input reg_wr,
	input [7:0] reg_addr,
	input [7:0] reg_wdata,
	input xfer_done,
	input lf_tick,
	input trigger_pin_mode_select,
	input boot_mode_strap,
	input host_interface_select,
	input soft_reset_pulse,
	input selftest_x_en,
	input selftest_z_en,
	input selftest_polarity,
	input [1:0] full_scale_range,
	input active_mode,
	input spi_three_wire
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// Accepted write without a reset request
	wire wr_ok = reg_wr && reg_addr == 8'h15 && !reg_wdata[7];
	// Ticks since last end of transfer; saturates so it never wraps
	reg [3:0] ticks_q;
	always @(posedge mclk or negedge rst_n)
		if (!rst_n)
			ticks_q <= 4'h0;
		else if (xfer_done)
			ticks_q <= 4'h0;
		else if (lf_tick && ticks_q != 4'hF)
			ticks_q <= ticks_q + 4'h1;
	axis_decode_a: assert property (wr_ok |-> ##2
		selftest_x_en == $past(reg_wdata[6:5] == 2'h1, 2) &&
		selftest_z_en == $past(reg_wdata[6:5] == 2'h2, 2)) else $error("axis");
	test_polarity_a: assert property (wr_ok |-> ##2
		selftest_polarity == $past(reg_wdata[4], 2)) else $error("polarity");
	range_select_a: assert property (wr_ok |-> ##2
		full_scale_range == $past(reg_wdata[2:1], 2)) else $error("range");
	active_bit_a: assert property (wr_ok && !trigger_pin_mode_select |-> ##2
		active_mode == $past(reg_wdata[0], 2)) else $error("active");
	wire_count_a: assert property (wr_ok |-> ##2
		spi_three_wire == ($past(reg_wdata[3], 2) && host_interface_select)) else $error("wires");
	pulse_once_a: assert property (
		soft_reset_pulse |=> !soft_reset_pulse) else $error("pulse");
	reset_defaults_a: assert property ($rose(soft_reset_pulse) |=>
		!selftest_x_en && !selftest_z_en && !selftest_polarity && !spi_three_wire &&
		full_scale_range == {1'b0, boot_mode_strap} && active_mode == boot_mode_strap)
		else $error("defaults");
	reset_delay_a: assert property (
		soft_reset_pulse |-> ticks_q >= 4'hA) else $error("delay");
	cover property (soft_reset_pulse);
	cover property (wr_ok ##2 selftest_z_en);
	cover property (spi_three_wire);
endmodule
bind sensor_control_register sensor_control_register_monitor sensor_control_register_monitor_i (
	.mclk, .rst_n, .reg_wr, .reg_addr, .reg_wdata, .xfer_done, .lf_tick,
	.trigger_pin_mode_select, .boot_mode_strap, .host_interface_select, .soft_reset_pulse,
	.selftest_x_en, .selftest_z_en, .selftest_polarity, .full_scale_range, .active_mode,
	.spi_three_wire);

// File: tb/host_front_end.sv
// Host side model: register strobes, end of transfer, oscillator ticks.
// Assumes mclk from the bench; drives 1 ns after each rising edge.
`timescale 1ns/1ns
module host_front_end (
	input mclk,
	input [7:0] reg_rdata,
	output reg reg_wr = 0,
	output reg reg_rd = 0,
	output reg [7:0] reg_addr = 8'h00,
	output reg [7:0] reg_wdata = 8'h00,
	output reg xfer_done = 0,
	output reg lf_tick = 0
);
	// One-cycle strobe; released bus shows inverted values
	task xfer(input w, input [7:0] a, input [7:0] d, output [7:0] q);
	begin
		@(posedge mclk) #1;
		{reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
		@(posedge mclk) #1;
		q = reg_rdata;
		{reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b00, ~a, ~d};
	end
	endtask
	// One oscillator tick, or with tick low a stop or chip-select release, then three idle cycles
	task pulse(input tick);
	begin
		@(posedge mclk) #1;
		{lf_tick, xfer_done} = {tick, !tick};
		@(posedge mclk) #1;
		{lf_tick, xfer_done} = 2'b00;
		repeat (3) @(posedge mclk);
		#1;
	end
	endtask
endmodule

// File: tb/sensor_control_register_tb.sv
// Bench for the primary sensor control register.
// Starts with SPI strapped and boot strap high; later scenarios drop each.
`timescale 1ns/1ns
module sensor_control_register_tb;
	reg mclk = 0;
	reg rst_n = 0;
	reg hibernate_exit = 0;
	reg trigger_pin_mode_select = 0;
	reg trig_pin_level = 0;
	reg boot_mode_strap = 1; // Strap level, changed only while reset is held
	reg host_interface_select = 1; // SPI strapped unless a scenario drops it
	wire reg_wr, reg_rd, xfer_done, lf_tick, soft_reset_pulse, mosi_bidir, miso_hiz;
	wire selftest_x_en, selftest_z_en, selftest_polarity, active_mode, spi_three_wire;
	wire [7:0] reg_addr, reg_wdata, reg_rdata;
	wire [1:0] full_scale_range;
	wire [8:0] outs = {selftest_x_en, selftest_z_en, selftest_polarity, full_scale_range,
		active_mode, spi_three_wire, mosi_bidir, miso_hiz};
	integer errors = 0;
	integer samples_checked = 0;
	integer pulses = 0;
	integer i;
	reg [7:0] rv;
	reg [7:0] vals [0:3] = '{8'h3C, 8'h46, 8'h03, 8'h60};
	always #5 mclk = ~mclk;
	// Count reset pulses seen
	always @(posedge mclk)
		if (soft_reset_pulse === 1'b1)
			pulses <= pulses + 1;
	sensor_control_register sensor_control_register_i (.mclk, .rst_n, .reg_wr, .reg_rd,
		.reg_addr, .reg_wdata, .reg_rdata, .xfer_done, .lf_tick, .hibernate_exit,
		.trigger_pin_mode_select, .boot_mode_strap, .host_interface_select,
		.trig_pin_level, .soft_reset_pulse, .selftest_x_en, .selftest_z_en,
		.selftest_polarity, .full_scale_range, .active_mode, .spi_three_wire, .mosi_bidir,
		.miso_hiz);
	host_front_end host_front_end_i (.mclk, .reg_rdata, .reg_wr, .reg_rd, .reg_addr,
		.reg_wdata, .xfer_done, .lf_tick);
	// Expected pins from the field map, SPI strapped, trigger mode off
	function [8:0] want(input [7:0] v);
		want = {v[6:5] == 2'h1, v[6:5] == 2'h2, v[4], v[2:1], v[0], v[3], v[3], v[3]};
	endfunction
	task check(input [31:0] got, input [31:0] exp);
	begin
		samples_checked = samples_checked + 1;
		if (got !== exp)
		begin
			errors = errors + 1;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	end
	endtask
	// Write, let outputs settle two edges, compare pins and readback
	task wr_chk(input [7:0] d, input [8:0] o, input [7:0] r);
	begin
		host_front_end_i.xfer(1, 8'h15, d, rv);
		repeat (2) @(posedge mclk);
		#1;
		check(outs, o);
		host_front_end_i.xfer(0, 8'h15, 8'h00, rv);
		check(rv, r);
	end
	endtask
	task t_defaults;
	begin
		host_front_end_i.xfer(0, 8'h15, 8'h00, rv);
		check(rv, 8'h03);
		host_front_end_i.xfer(0, 8'h16, 8'h00, rv);
		check(rv, 8'h00);
	end
	endtask
	task t_modes;
	begin
		for (i = 0; i < 4; i = i + 1)
			wr_chk(vals[i], want(vals[i]), vals[i]); // No data reads in self
		trigger_pin_mode_select = 1;
		wr_chk(8'h01, 9'h000, 8'h00);
		// Pin high: mode and readback follow the synchronised pin
		trig_pin_level = 1;
		wr_chk(8'h00, 9'h008, 8'h01);
		trigger_pin_mode_select = 0;
		trig_pin_level = 0;
		wr_chk(8'h08, 9'h007, 8'h08);
		// I2C strapped: wire count bit stored but without effect
		host_interface_select = 0;
		wr_chk(8'h08, 9'h000, 8'h08);
		host_interface_select = 1;
		hibernate_exit = 1;
		@(posedge mclk) #1 hibernate_exit = 0;
		repeat (3) @(posedge mclk);
		#1;
		check(outs, 9'h000);
	end
	endtask
	// Request while active; no start before stop, then exactly ten ticks
	task t_soft_reset;
	begin
		wr_chk(8'h3D, want(8'h3D), 8'h3D);
		host_front_end_i.xfer(1, 8'h15, 8'hBD, rv);
		for (i = 0; i < 12; i = i + 1)
			host_front_end_i.pulse(1);
		check(pulses, 0);
		host_front_end_i.pulse(0);
		for (i = 0; i < 9; i = i + 1)
			host_front_end_i.pulse(1);
		check(pulses, 0);
		host_front_end_i.pulse(1);
		check(pulses, 1);
		repeat (20) @(posedge mclk);
		host_front_end_i.xfer(0, 8'h15, 8'h00, rv);
		check(rv, 8'h03);
		check(outs, want(8'h03));
		// Further ticks must not start a second sequence
		for (i = 0; i < 11; i = i + 1)
			host_front_end_i.pulse(1);
		check(pulses, 1);
	end
	endtask
	// Strap low: second reset mid-run, then a soft reset reloads all zeros
	task t_strap_low;
	begin
		boot_mode_strap = 0;
		rst_n = 0;
		repeat (4) @(posedge mclk);
		#1 rst_n = 1;
		repeat (6) @(posedge mclk);
		#1;
		check(outs, 9'h000);
		host_front_end_i.xfer(0, 8'h15, 8'h00, rv);
		check(rv, 8'h00);
		wr_chk(8'h2B, want(8'h2B), 8'h2B);
		host_front_end_i.xfer(1, 8'h15, 8'hAB, rv);
		host_front_end_i.pulse(0);
		for (i = 0; i < 10; i = i + 1)
			host_front_end_i.pulse(1);
		repeat (20) @(posedge mclk);
		host_front_end_i.xfer(0, 8'h15, 8'h00, rv);
		check(rv, 8'h00);
		check(outs, 9'h000);
		check(pulses, 2);
	end
	endtask
	task final_report;
	begin
		if (errors == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	end
	endtask
	initial
	begin
		#50000;
		errors = errors + 1;
		final_report;
	end
	initial
	begin
		repeat (16) @(posedge mclk);
		#1 rst_n = 1;
		repeat (6) @(posedge mclk);
		t_defaults;
		t_modes;
		t_soft_reset;
		t_strap_low;
		final_report;
	end
endmodule
